// >>> pstx_pkg.sv
// Constants shared by the parallel-to-serial display link transmitter
`default_nettype none
package pstx_pkg;
    localparam int LANES = 4;
    localparam int SLOTS = 7;
    localparam int WORD_W = LANES * SLOTS;
    localparam int PER_W = 8;
    localparam int CLK_HIGH_SLOTS = 4;
    localparam int REF_PERIOD_NS = 8;
    localparam int LOCK_TIME_NS = 1000000;
    localparam int LOCK_CYCLES =
        (LOCK_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    localparam int DIS_TIME_NS = 250;
    localparam int DIS_CYCLES = DIS_TIME_NS / REF_PERIOD_NS;
    localparam logic [2:0] SLOT_STEP = 3'h7;
    localparam logic [2:0] SLOT_LAST = 3'h6;
    typedef enum logic [1:0] {
        PSTX_OFF,
        PSTX_LOCKING,
        PSTX_RUN
    } pstx_state_e;
endpackage
`default_nettype wire

// >>> pstx_rx_model.sv
// Behavioural link receiver that rebuilds words from the serial lanes
`default_nettype none
module pstx_rx_model
    import pstx_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [LANES-1:0] serial_lanes_i,
    input wire logic forwarded_link_clock_i,
    output logic [WORD_W-1:0] word_o,
    output logic word_stb_o,
    output logic [7:0] period_o,
    output logic [7:0] high_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fwd_q;
    logic [7:0] elapsed_q;
    logic [7:0] high_cnt_q;
    logic [WORD_W-1:0] acc_q;
    // Frame timing from the forwarded clock, slices taken in the first cycle of each slot
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fwd_q <= 1'b0;
            elapsed_q <= 8'h00;
            high_cnt_q <= 8'h00;
            acc_q <= '0;
            word_o <= '0;
            word_stb_o <= 1'b0;
            period_o <= 8'h00;
            high_o <= 8'h00;
        end else begin
            fwd_q <= forwarded_link_clock_i;
            word_stb_o <= 1'b0;
            if (forwarded_link_clock_i && !fwd_q) begin
                period_o <= elapsed_q + 8'h01;
                high_o <= high_cnt_q;
                word_o <= acc_q;
                word_stb_o <= 1'b1;
                elapsed_q <= 8'h00;
                high_cnt_q <= 8'h01;
                // Slot 0 stands on the lanes as the clock rise is seen
                for (int l = 0; l < LANES; l++) begin
                    acc_q[SLOTS * l] <= serial_lanes_i[l];
                end
            end else begin
                elapsed_q <= elapsed_q + 8'h01;
                high_cnt_q <= high_cnt_q + {7'h00, forwarded_link_clock_i};
                // Slot n taken in its first cycle, so a frame one cycle
                // shorter than the last still shows slot 6
                for (int n = 1; n < SLOTS; n++) begin
                    if (int'(elapsed_q) + 1 ==
                        (n * int'(period_o) + SLOTS - 1) / SLOTS) begin
                        for (int l = 0; l < LANES; l++) begin
                            acc_q[SLOTS * l + n] <= serial_lanes_i[l];
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> pstx_sync.sv
// Two-flop synchroniser for a group of pins from outside the clock domain
`default_nettype none
module pstx_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [W-1:0] din_i,
    output logic [W-1:0] dout_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce_i) begin
            meta_q <= din_i;
            sync_q <= meta_q;
        end
    end

    assign dout_o = sync_q;
endmodule
`default_nettype wire

// >>> pstx_tx.sv
// Parallel-to-serial display link transmitter: capture, slicing, clocking
// Operation
// - Four 7-bit shift registers load in parallel and empty serially.
// - All 28 parallel bits are captured once per selected pixel edge.
// - The edge-select level picks rising or falling capture.
// - Each lane shifts 7 bits per pixel period at seven times its rate.
// - A forwarded clock at the pixel frequency goes with the lanes.
// - Bit position 0 starts on the forwarded clock's rising edge.
// - Bit position n starts n sevenths of a period after that edge.
// - The forwarded clock is high four sevenths, low three sevenths.
// - Shutdown stops the clocking and turns the output drivers off.
// - Shutdown low clears the lane shift registers and timing counters to zero.
// - After shutdown rises, outputs become valid after about 1 ms.
// - After shutdown falls, the forwarded clock goes low quickly.
`default_nettype none
module pstx_tx
    import pstx_pkg::*;
#(
    parameter int LOCK_CYCLES_P = LOCK_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic input_pixel_clock_i,
    input wire logic capture_edge_select_i,
    input wire logic shutdown_clear_n_i,
    input wire logic [WORD_W-1:0] parallel_pixel_bits_i,
    output logic [LANES-1:0] serial_lanes_o,
    output logic forwarded_link_clock_o,
    output logic lanes_oe_n_o,
    output logic clock_oe_n_o,
    output logic link_valid_o
);
    localparam int DIS_MAX = DIS_CYCLES;

    logic [WORD_W+2:0] pins_s;
    logic [WORD_W-1:0] data_s;
    logic pclk_s;
    logic sel_s;
    logic sh_n_s;
    logic pclk_prev_q;
    logic rise;
    logic fall;
    logic cap;
    pstx_state_e state_q;
    logic [31:0] lock_cnt_q;
    logic seen_cap_q;
    logic [PER_W-1:0] cnt_q;
    logic [PER_W-1:0] period_q;
    logic [PER_W+3:0] acc_q;
    logic [PER_W+3:0] acc_nx;
    logic [2:0] slot_q;
    logic fwd_q;

    // All pins pass two flops before use
    pstx_sync #(.W(WORD_W + 3)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .din_i({shutdown_clear_n_i, capture_edge_select_i,
                input_pixel_clock_i, parallel_pixel_bits_i}),
        .dout_o(pins_s)
    );
    assign data_s = pins_s[WORD_W-1:0];
    assign pclk_s = pins_s[WORD_W];
    assign sel_s = pins_s[WORD_W+1];
    assign sh_n_s = pins_s[WORD_W+2];

    // Edge detection on the synchronised pixel clock
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pclk_prev_q <= 1'b0;
        end else if (ce_i) begin
            pclk_prev_q <= pclk_s;
        end
    end
    assign rise = pclk_s & ~pclk_prev_q;
    assign fall = ~pclk_s & pclk_prev_q;
    assign cap = (sel_s ? rise : fall) & sh_n_s;

    // Power state: off, waiting for lock, running
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= PSTX_OFF;
            lock_cnt_q <= '0;
            seen_cap_q <= 1'b0;
        end else if (ce_i) begin
            case (state_q)
                PSTX_OFF: begin
                    lock_cnt_q <= '0;
                    seen_cap_q <= 1'b0;
                    if (sh_n_s) begin
                        state_q <= PSTX_LOCKING;
                    end
                end
                PSTX_LOCKING: begin
                    if (!sh_n_s) begin
                        state_q <= PSTX_OFF;
                    end else begin
                        if (cap) begin
                            seen_cap_q <= 1'b1;
                        end
                        if (lock_cnt_q >= 32'(LOCK_CYCLES_P - 1) &&
                            seen_cap_q) begin
                            state_q <= PSTX_RUN;
                        end else if (lock_cnt_q < 32'(LOCK_CYCLES_P)) begin
                            lock_cnt_q <= lock_cnt_q + 32'h1;
                        end
                    end
                end
                PSTX_RUN: begin
                    if (!sh_n_s) begin
                        state_q <= PSTX_OFF;
                    end
                end
                default: state_q <= PSTX_OFF;
            endcase
        end
    end

    // Pixel period measured in reference cycles
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= '0;
            period_q <= '0;
        end else if (ce_i) begin
            if (!sh_n_s) begin
                cnt_q <= '0;
                period_q <= '0;
            end else if (cap) begin
                cnt_q <= '0;
                period_q <= cnt_q + PER_W'(1);
            end else if (cnt_q != '1) begin
                cnt_q <= cnt_q + PER_W'(1);
            end
        end
    end

    // Slot n begins once 7 * elapsed cycles reaches n periods
    assign acc_nx = acc_q + (PER_W + 4)'(SLOT_STEP);
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_q <= '0;
            slot_q <= '0;
        end else if (ce_i) begin
            if (!sh_n_s || cap) begin
                acc_q <= '0;
                slot_q <= '0;
            end else if (acc_nx >= {4'h0, period_q}) begin
                acc_q <= acc_nx - {4'h0, period_q};
                if (slot_q != SLOT_LAST) begin
                    slot_q <= slot_q + 3'h1;
                end
            end else begin
                acc_q <= acc_nx;
            end
        end
    end

    // Lane shift registers: parallel load on capture, shift per slot
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [SLOTS-1:0] lane_q;
        always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                lane_q <= '0;
            end else if (ce_i) begin
                if (!sh_n_s) begin
                    lane_q <= '0;
                end else if (cap) begin
                    lane_q <= data_s[l*SLOTS +: SLOTS];
                end else if (acc_nx >= {4'h0, period_q} &&
                             slot_q != SLOT_LAST) begin
                    lane_q <= {1'b0, lane_q[SLOTS-1:1]};
                end
            end
        end
        assign serial_lanes_o[l] = lane_q[0];
    end

    // Forwarded clock: high for slots 0..3, low for 4..6
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fwd_q <= 1'b0;
        end else if (ce_i) begin
            if (!sh_n_s || state_q == PSTX_OFF) begin
                fwd_q <= 1'b0;
            end else if (cap) begin
                fwd_q <= 1'b1;
            end else if (acc_nx >= {4'h0, period_q} &&
                         slot_q == 3'(CLK_HIGH_SLOTS - 1)) begin
                fwd_q <= 1'b0;
            end
        end
    end

    assign forwarded_link_clock_o = fwd_q;
    assign lanes_oe_n_o = (state_q == PSTX_OFF);
    assign clock_oe_n_o = (state_q == PSTX_OFF);
    assign link_valid_o = (state_q == PSTX_RUN);

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i || !ce_i);

    a_off_clock_low: assert property (
        state_q == PSTX_OFF |-> !forwarded_link_clock_o)
        else $error("forwarded clock high while off");
    a_off_drivers: assert property (
        state_q == PSTX_OFF |-> lanes_oe_n_o && clock_oe_n_o
            && !link_valid_o)
        else $error("drivers on while off");
    a_shutdown_time: assert property (
        $fell(shutdown_clear_n_i) ##1 !shutdown_clear_n_i [*2]
            |-> ##[1:DIS_MAX] clock_oe_n_o)
        else $error("shutdown not reached in time");
    a_clear_regs: assert property (
        !sh_n_s |=> serial_lanes_o == '0 && period_q == '0 && slot_q == '0)
        else $error("registers not cleared by shutdown");
    a_load_word: assert property (
        cap |=> serial_lanes_o[0] == $past(data_s[0])
            && serial_lanes_o[LANES-1] == $past(data_s[(LANES-1)*SLOTS]))
        else $error("word not captured");
    a_edge_select: assert property (
        sh_n_s && (sel_s ? fall : rise) && !$past(cap)
            |=> !(slot_q == '0 && acc_q == '0 && $past(slot_q) != '0))
        else $error("capture on wrong edge");
    a_clock_start: assert property (
        cap && state_q != PSTX_OFF |=> forwarded_link_clock_o
            && slot_q == '0)
        else $error("slot 0 not aligned to clock rise");
    a_slot_step: assert property (
        slot_q != $past(slot_q) |-> slot_q == '0
            || slot_q == $past(slot_q) + 3'h1)
        else $error("slot skipped");
    a_clock_duty: assert property (
        slot_q >= 3'(CLK_HIGH_SLOTS) && !$past(cap) && !cap
            |-> !forwarded_link_clock_o)
        else $error("forwarded clock high in low slots");
    a_lock_wait: assert property (
        $rose(link_valid_o) |-> $past(lock_cnt_q) >= 32'(LOCK_CYCLES_P - 1))
        else $error("valid before lock time");

    c_rise_capture: cover property (cap && sel_s);
    c_fall_capture: cover property (cap && !sel_s);
    c_reach_run: cover property ($rose(link_valid_o));
    c_last_slot: cover property (slot_q == SLOT_LAST
        && forwarded_link_clock_o == 1'b0);
endmodule
`default_nettype wire

// >>> tb_pstx_tx.sv
// Self-checking bench for the display link transmitter
`default_nettype none
module tb_pstx_tx;
    import pstx_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOCK_P = 200;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic pix = 1'b0;
    logic sel = 1'b1;
    logic shdn_n = 1'b0;
    logic ce = 1'b1;
    logic [WORD_W-1:0] data = '0;
    logic [WORD_W-1:0] word_a = '0;
    logic [WORD_W-1:0] word_b = '0;
    logic [LANES-1:0] lanes;
    logic fwd, lanes_oe_n, clock_oe_n, valid, rx_stb;
    logic [WORD_W-1:0] rx_word;
    logic [7:0] rx_per, rx_high;
    int mismatches = 0;
    int total_checks = 0;

    pstx_tx #(.LOCK_CYCLES_P(LOCK_P)) dut (.ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i), .ce_i(ce), .input_pixel_clock_i(pix),
        .capture_edge_select_i(sel), .shutdown_clear_n_i(shdn_n),
        .parallel_pixel_bits_i(data), .serial_lanes_o(lanes),
        .forwarded_link_clock_o(fwd), .lanes_oe_n_o(lanes_oe_n),
        .clock_oe_n_o(clock_oe_n), .link_valid_o(valid));
    pstx_rx_model rx (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .serial_lanes_i(lanes), .forwarded_link_clock_i(fwd),
        .word_o(rx_word), .word_stb_o(rx_stb), .period_o(rx_per),
        .high_o(rx_high));

    // Reference clock
    initial begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    // Pixel clock, 125 ns, word_a held around rise, word_b around fall
    initial begin
        #0.125; // Keeps pixel edges off the reference edges
        forever begin
            pix = 1'b1;
            #31.25 data = word_b;
            #31.25 pix = 1'b0;
            #31.25 data = word_a;
            #31.25;
        end
    end

    task automatic conclude();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check_word(input logic [WORD_W-1:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_frames(input int n);
        int k = 0;
        int c = 0;
        while (k < n && c < 3000) begin
            @(negedge ref_clk_i);
            c++;
            if (rx_stb === 1'b1) k++;
        end
        if (k < n) begin
            mismatches++;
            conclude();
        end
    endtask
    task automatic t_power_up();
        int c = 0;
        @(negedge ref_clk_i);
        shdn_n = 1'b1;
        while (valid !== 1'b1 && c < LOCK_P + 300) begin
            @(negedge ref_clk_i);
            c++;
        end
        check_flag(c >= LOCK_P, 1'b1);
        check_flag(lanes_oe_n | clock_oe_n, 1'b0);
        if (valid !== 1'b1) begin
            mismatches++;
            conclude();
        end
    endtask
    task automatic t_clock_shape();
        int d;
        wait_frames(3);
        check_flag(rx_per == 8'h0f || rx_per == 8'h10, 1'b1);
        d = 7 * int'(rx_high) - 4 * int'(rx_per);
        check_flag(d >= -7 && d <= 7, 1'b1);
    endtask
    task automatic t_freeze();
        logic [LANES-1:0] l0;
        logic f0;
        @(negedge ref_clk_i);
        ce = 1'b0;
        l0 = lanes;
        f0 = fwd;
        repeat (20) @(negedge ref_clk_i);
        check_word({24'h000000, lanes}, {24'h000000, l0});
        check_flag(fwd, f0);
        ce = 1'b1;
    endtask
    task automatic t_words();
        logic [WORD_W-1:0] pat [4] = '{28'h0000001, 28'h5a5a5a5,
            28'h8000000, 28'h0123456};
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk_i);
            sel = i[0];
            word_a = pat[i];
            word_b = ~pat[i];
            wait_frames(5);
            check_word(rx_word, sel ? word_a : word_b);
        end
    endtask
    task automatic t_shutdown();
        @(negedge ref_clk_i);
        shdn_n = 1'b0;
        repeat (DIS_CYCLES) @(negedge ref_clk_i);
        check_flag(fwd, 1'b0);
        check_flag(lanes_oe_n & clock_oe_n, 1'b1);
        check_flag(valid, 1'b0);
        check_word({24'h000000, lanes}, '0);
    endtask

    // Main sequence
    initial begin
        repeat (3) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        t_power_up();
        t_clock_shape();
        t_freeze();
        t_words();
        t_shutdown();
        t_power_up();
        t_words();
        conclude();
    end
endmodule
`default_nettype wire
